// ==== follow_front_end.sv ====
// External follow, ratio and counter front end of the motion controller
`timescale 1ns/1ps
`include "follow_params.svh"
module follow_front_end
#(
    parameter int SHIFT_PERIOD_W = 16
)
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    // Follow input pins
    input  wire logic        IN_A,
    input  wire logic        IN_B,
    // Command port
    input  wire logic        CMD_STROBE,
    input  wire logic [3:0]  CMD_CODE,
    input  wire logic [31:0] CMD_VALUE,
    input  wire logic [7:0]  HOST_MODE_LETTER,
    // State flags from the rest of the controller
    input  wire logic [15:0] STATE_FLAGS,
    // Results
    output logic [31:0]      AUX_COUNTER,
    output logic [31:0]      FOLLOW_TARGET,
    output logic             FOLLOW_ACTIVE,
    output logic [7:0]       MODE_QUERY,
    output logic [7:0]       STATUS_BYTE_QUERY,
    output logic [15:0]      STATUS_WORD_QUERY,
    output logic             CMD_REJECT
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]                 sync_a;
        logic [1:0]                 sync_b;
        follow_pkg::follow_mode_t   mode;
        follow_pkg::res_t           res;
        logic                       step_in;
        logic signed [31:0]         ctr;
        logic signed [31:0]         mul;
        logic signed [31:0]         div;
        logic signed [31:0]         shift_left;
        logic [SHIFT_PERIOD_W-1:0]  shift_period;
        logic [SHIFT_PERIOD_W-1:0]  shift_cnt;
        logic                       ratio_clear;
        logic [7:0]                 letter;
        logic [7:0]                 sbyte;
        logic [15:0]                sword;
        logic [31:0]                ctr_out;
        logic [31:0]                tgt_out;
        logic                       active;
        logic                       reject;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    follow_pkg::count_ev_t ev;
    follow_pkg::count_ev_t ratio_ev;
    logic signed [31:0]    ratio_target;
    logic                  shift_step;
    logic                  in_ratio;
    logic                  tracking;
    logic                  following;
    logic signed [31:0]    abs_mul;
    logic signed [31:0]    abs_div;
    logic                  ratio_ok;

    // ****************************************************************
    // Decoder and ratio engine
    // ****************************************************************
    quad_step_decoder u_dec
    (
        .clk       (CLK),
        .rst_b     (RST_B),
        .ce        (CE),
        .in_a      (s_q.sync_a[1]),
        .in_b      (s_q.sync_b[1]),
        .step_mode (s_q.step_in),
        .res       (tracking ? follow_pkg::RES_FULL : s_q.res),
        .ev        (ev)
    );

    assign in_ratio = (s_q.mode == follow_pkg::MODE_ENC_RATIO) ||
                      (s_q.mode == follow_pkg::MODE_STEP_RATIO);
    assign ratio_ev = in_ratio ? ev : '0;
    assign shift_step = in_ratio && (s_q.shift_left != '0) &&
                        (s_q.shift_cnt == '0);

    ratio_accum #(.W(32)) u_ratio
    (
        .clk        (CLK),
        .rst_b      (RST_B),
        .ce         (CE),
        .clear      (s_q.ratio_clear),
        .mul        (s_q.mul),
        .div        (s_q.div),
        .ev         (ratio_ev),
        .shift_step (shift_step),
        .shift_neg  (s_q.shift_left[31]),
        .target     (ratio_target)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.reject = 1'b0;
        s_d.ratio_clear = 1'b0;
        s_d.sync_a = {s_q.sync_a[0], IN_A};
        s_d.sync_b = {s_q.sync_b[0], IN_B};
        tracking = (s_q.mode == follow_pkg::MODE_ENC_TRACK) ||
                   (s_q.mode == follow_pkg::MODE_STEP_TRACK);
        following = (s_q.mode == follow_pkg::MODE_FOLLOW) ||
                    (s_q.mode == follow_pkg::MODE_STEP) ||
                    (s_q.mode == follow_pkg::MODE_CAM) || in_ratio;
        abs_mul = s_q.mul[31] ? -s_q.mul : s_q.mul;
        abs_div = s_q.div[31] ? -s_q.div : s_q.div;
        ratio_ok = (abs_div != '0) &&
                   ({32'h0, abs_mul} < ({32'h0, abs_div} << `RATIO_LIMIT_SHIFT));

        // Counter counts in track-only and in every follow mode
        if (tracking || following)
        begin
            if (ev.up)
                s_d.ctr = s_q.ctr + 32'sh1;
            else if (ev.down)
                s_d.ctr = s_q.ctr - 32'sh1;
        end

        // Phase shift paced by the commanded period
        if (in_ratio && s_q.shift_left != '0)
        begin
            s_d.shift_cnt = (s_q.shift_cnt == '0) ? s_q.shift_period
                                                   : s_q.shift_cnt - 1'b1;
            if (shift_step)
                s_d.shift_left = s_q.shift_left[31] ? s_q.shift_left + 32'sh1
                                                    : s_q.shift_left - 32'sh1;
        end

        if (CMD_STROBE)
        begin
            case (CMD_CODE)
                `CMD_FULL_RES, `CMD_HALF_RES, `CMD_QUARTER_RES:
                begin
                    s_d.res = (CMD_CODE == `CMD_FULL_RES) ? follow_pkg::RES_FULL :
                              (CMD_CODE == `CMD_HALF_RES) ? follow_pkg::RES_HALF :
                                                            follow_pkg::RES_QUARTER;
                    s_d.mode = follow_pkg::MODE_FOLLOW;
                    s_d.step_in = 1'b0;
                end
                `CMD_ENC_TRACK, `CMD_STEP_TRACK:
                begin
                    if (following)
                        s_d.reject = 1'b1;
                    else
                    begin
                        s_d.ctr = `CTR_RESET;
                        s_d.step_in = (CMD_CODE == `CMD_STEP_TRACK);
                        s_d.mode = s_d.step_in ? follow_pkg::MODE_STEP_TRACK
                                               : follow_pkg::MODE_ENC_TRACK;
                    end
                end
                `CMD_STEP_FOLLOW:
                begin
                    s_d.mode = follow_pkg::MODE_STEP;
                    s_d.step_in = 1'b1;
                end
                `CMD_ENC_RATIO, `CMD_STEP_RATIO:
                begin
                    // Needs matching decode mode and a legal ratio
                    if (!ratio_ok ||
                        ((CMD_CODE == `CMD_STEP_RATIO) != s_q.step_in) ||
                        tracking || s_q.mode == follow_pkg::MODE_OFF)
                        s_d.reject = 1'b1;
                    else
                    begin
                        s_d.mode = s_q.step_in ? follow_pkg::MODE_STEP_RATIO
                                               : follow_pkg::MODE_ENC_RATIO;
                        s_d.ratio_clear = 1'b1;
                        s_d.shift_left = '0;
                    end
                end
                `CMD_CAM:
                begin
                    s_d.mode = follow_pkg::MODE_CAM;
                    s_d.step_in = 1'b0;
                end
                `CMD_SET_MUL:
                    s_d.mul = CMD_VALUE;
                `CMD_SET_DIV:
                    s_d.div = CMD_VALUE;
                `CMD_SET_SHIFT:
                begin
                    // Value low half is distance, high half is step period
                    s_d.shift_left = {{16{CMD_VALUE[15]}}, CMD_VALUE[15:0]};
                    s_d.shift_period = SHIFT_PERIOD_W'(CMD_VALUE[31:16]);
                    s_d.shift_cnt = '0;
                end
                `CMD_HOST_MODE, `CMD_STOP:
                    s_d.mode = (CMD_CODE == `CMD_STOP) ? follow_pkg::MODE_OFF
                                                       : follow_pkg::MODE_HOST;
                default:
                    s_d.reject = 1'b1;
            endcase
        end

        // Mode letter; host-run modes pass their own letter through
        case (s_q.mode)
            follow_pkg::MODE_FOLLOW:      s_d.letter = `LTR_F;
            follow_pkg::MODE_STEP:        s_d.letter = `LTR_S;
            follow_pkg::MODE_ENC_RATIO:   s_d.letter = `LTR_X;
            follow_pkg::MODE_STEP_RATIO:  s_d.letter = `LTR_X;
            follow_pkg::MODE_CAM:         s_d.letter = `LTR_C;
            follow_pkg::MODE_HOST:        s_d.letter = HOST_MODE_LETTER;
            default:                      s_d.letter = STATE_FLAGS[`ST_MOTOR_OFF_BIT] ?
                                                       `LTR_O : HOST_MODE_LETTER;
        endcase

        s_d.sbyte = STATE_FLAGS[7:0];
        s_d.sword = STATE_FLAGS;
        s_d.ctr_out = s_d.ctr;
        s_d.tgt_out = in_ratio ? ratio_target : s_d.ctr;
        s_d.active = following;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s_q <= '0;
            s_q.mode <= follow_pkg::MODE_OFF;
            s_q.mul <= `MUL_RESET;
            s_q.div <= `DIV_RESET;
            s_q.letter <= `LTR_O;
        end
        else if (CE)
            s_q <= s_d;
    end

    assign AUX_COUNTER       = s_q.ctr_out;
    assign FOLLOW_TARGET     = s_q.tgt_out;
    assign FOLLOW_ACTIVE     = s_q.active;
    assign MODE_QUERY        = s_q.letter;
    assign STATUS_BYTE_QUERY = s_q.sbyte;
    assign STATUS_WORD_QUERY = s_q.sword;
    assign CMD_REJECT        = s_q.reject;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence track_cmd_s;
        CE && CMD_STROBE && (CMD_CODE == `CMD_ENC_TRACK) && !following;
    endsequence

    a_track_clears_ctr: assert property (@(posedge CLK) disable iff (!RST_B)
        track_cmd_s |=> (s_q.ctr == 32'sh0) && (AUX_COUNTER == 32'h0))
        else $error("Track-only did not clear counter");

    a_track_rejected: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && CMD_STROBE && CMD_CODE == `CMD_STEP_TRACK && following)
        |=> CMD_REJECT && $stable(s_q.mode))
        else $error("Track-only accepted during follow");

    a_ratio_bound: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && CMD_STROBE && CMD_CODE == `CMD_ENC_RATIO && !ratio_ok) |=> CMD_REJECT)
        else $error("Out of range ratio accepted");

    a_ratio_enter: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && CMD_STROBE && CMD_CODE == `CMD_ENC_RATIO && ratio_ok && !s_q.step_in
         && s_q.mode == follow_pkg::MODE_FOLLOW)
        |=> s_q.mode == follow_pkg::MODE_ENC_RATIO && s_q.shift_left == '0)
        else $error("Ratio command did not enter ratio mode");

    a_shift_moves: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && shift_step && !s_q.shift_left[31] && !(CMD_STROBE))
        |=> s_q.shift_left == $past(s_q.shift_left) - 32'sh1)
        else $error("Phase shift did not progress");

    a_mode_letter: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && s_q.mode == follow_pkg::MODE_FOLLOW) |=> MODE_QUERY == `LTR_F)
        else $error("Follow mode letter wrong");

    a_status_byte: assert property (@(posedge CLK) disable iff (!RST_B)
        CE |=> STATUS_BYTE_QUERY == $past(STATE_FLAGS[7:0]) &&
               STATUS_WORD_QUERY == $past(STATE_FLAGS))
        else $error("Status byte or word mismatch");

    a_track_counts: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && tracking && ev.up && !CMD_STROBE) |=> s_q.ctr == $past(s_q.ctr) + 32'sh1)
        else $error("Track-only count missed");

    a_active_flag: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && s_q.mode == follow_pkg::MODE_CAM) |=> FOLLOW_ACTIVE)
        else $error("Follow active flag missing");

endmodule

// ==== follow_params.svh ====
// Constants for the external follow and ratio front end
`ifndef FOLLOW_PARAMS_SVH
`define FOLLOW_PARAMS_SVH

// Command codes on CMD_CODE
`define CMD_NONE          4'h0
`define CMD_FULL_RES      4'h1
`define CMD_HALF_RES      4'h2
`define CMD_QUARTER_RES   4'h3
`define CMD_ENC_TRACK     4'h4
`define CMD_STEP_TRACK    4'h5
`define CMD_STEP_FOLLOW   4'h6
`define CMD_ENC_RATIO     4'h7
`define CMD_STEP_RATIO    4'h8
`define CMD_CAM           4'h9
`define CMD_SET_MUL       4'ha
`define CMD_SET_DIV       4'hb
`define CMD_SET_SHIFT     4'hc
`define CMD_HOST_MODE     4'hd
`define CMD_STOP          4'he

// Ratio limit: |ratio| < 256, so |mul| < 256 * |div|
`define RATIO_LIMIT_SHIFT 8

// Mode letters
`define LTR_P 8'h50
`define LTR_R 8'h52
`define LTR_V 8'h56
`define LTR_T 8'h54
`define LTR_F 8'h46
`define LTR_S 8'h53
`define LTR_C 8'h43
`define LTR_W 8'h57
`define LTR_X 8'h58
`define LTR_E 8'h45
`define LTR_O 8'h4f
`define LTR_H 8'h48

// Status byte fields
`define ST_TRAJ_BIT       0
`define ST_MOTOR_OFF_BIT  7

// Reset values
`define CTR_RESET         32'h0000_0000
`define MUL_RESET         32'h0000_0001
`define DIV_RESET         32'h0000_0001

`endif

// ==== follow_pkg.sv ====
// Types shared by the follow front end
package follow_pkg;

    typedef enum logic [3:0] {
        MODE_OFF        = 4'b0000,
        MODE_ENC_TRACK  = 4'b0001,
        MODE_STEP_TRACK = 4'b0010,
        MODE_FOLLOW     = 4'b0011,
        MODE_STEP       = 4'b0100,
        MODE_ENC_RATIO  = 4'b0101,
        MODE_STEP_RATIO = 4'b0110,
        MODE_CAM        = 4'b0111,
        MODE_HOST       = 4'b1000
    } follow_mode_t;

    typedef enum logic [1:0] {
        RES_FULL    = 2'b00,
        RES_HALF    = 2'b01,
        RES_QUARTER = 2'b10
    } res_t;

    typedef struct packed {
        logic        up;
        logic        down;
    } count_ev_t;

    typedef struct packed {
        logic [3:0]  code;
        logic [31:0] value;
        logic        strobe;
    } cmd_t;

endpackage

// ==== quad_step_decoder.sv ====
// Quadrature and step/direction decoder with resolution select
`timescale 1ns/1ps
module quad_step_decoder
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    // Synchronised pins
    input  wire logic               in_a,
    input  wire logic               in_b,
    // Configuration
    input  wire logic               step_mode,
    input  wire follow_pkg::res_t   res,
    // Count events
    output follow_pkg::count_ev_t   ev
);

    typedef struct packed {
        logic [1:0]              prev;
        logic [1:0]              sub;
        follow_pkg::count_ev_t   ev;
    } dec_state_t;

    dec_state_t s_q;
    dec_state_t s_d;
    logic       fwd;
    logic       rev;
    logic       stp;
    logic [1:0] cur;

    always_comb
    begin
        s_d = s_q;
        cur = {in_a, in_b};
        fwd = 1'b0;
        rev = 1'b0;
        stp = 1'b0;
        s_d.ev = '0;
        // Gray order 00-01-11-10; a double change is dropped
        case ({s_q.prev, cur})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: fwd = 1'b1;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: rev = 1'b1;
            default:                             ;
        endcase
        // Step on rising edge of A, B gives direction
        stp = in_a & ~s_q.prev[1];
        if (step_mode)
        begin
            s_d.ev.up   = stp & ~in_b;
            s_d.ev.down = stp & in_b;
        end
        else if (fwd | rev)
        begin
            s_d.sub = fwd ? s_q.sub + 2'h1 : s_q.sub - 2'h1;
            case (res)
                follow_pkg::RES_FULL:
                begin
                    s_d.ev.up   = fwd;
                    s_d.ev.down = rev;
                end
                follow_pkg::RES_HALF:
                begin
                    s_d.ev.up   = fwd & (s_d.sub[0] == 1'b0);
                    s_d.ev.down = rev & (s_d.sub[0] == 1'b1);
                end
                default:
                begin
                    s_d.ev.up   = fwd & (s_d.sub == 2'h0);
                    s_d.ev.down = rev & (s_d.sub == 2'h3);
                end
            endcase
        end
        s_d.prev = cur;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign ev = s_q.ev;

    a_illegal_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !step_mode && (s_q.prev ^ {in_a, in_b}) == 2'b11) |=> !s_q.ev.up && !s_q.ev.down)
        else $error("Double phase change produced a count");

    a_no_both_dirs: assert property (@(posedge clk) disable iff (!rst_b)
        !(s_q.ev.up && s_q.ev.down))
        else $error("Decoder counted up and down at once");

endmodule

// ==== ratio_accum.sv ====
// Ratio accumulator: mul/div fractional follow with phase shift
`timescale 1ns/1ps
module ratio_accum
#(
    parameter int W = 32
)
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    input  wire logic               clear,
    // Ratio terms
    input  wire logic signed [W-1:0] mul,
    input  wire logic signed [W-1:0] div,
    // Input counts and shift
    input  wire follow_pkg::count_ev_t ev,
    input  wire logic               shift_step,
    input  wire logic               shift_neg,
    // Target step
    output logic signed [W-1:0]     target
);

    typedef struct packed {
        logic signed [W-1:0] rem;
        logic signed [W-1:0] tgt;
    } acc_state_t;

    acc_state_t s_q;
    acc_state_t s_d;
    logic signed [W-1:0] absdiv;
    logic signed [W-1:0] add;

    always_comb
    begin
        s_d = s_q;
        absdiv = div[W-1] ? -div : div;
        add = '0;
        if (ev.up)
            add = mul;
        else if (ev.down)
            add = -mul;
        // Remainder carries the fraction so no count is lost
        s_d.rem = s_q.rem + (div[W-1] ? -add : add);
        if (absdiv != '0)
        begin
            if (s_d.rem >= absdiv)
            begin
                s_d.rem = s_d.rem - absdiv;
                s_d.tgt = s_q.tgt + W'(1);
            end
            else if (s_d.rem <= -absdiv)
            begin
                s_d.rem = s_d.rem + absdiv;
                s_d.tgt = s_q.tgt - W'(1);
            end
        end
        if (shift_step)
            s_d.tgt = shift_neg ? s_d.tgt - W'(1) : s_d.tgt + W'(1);
        if (clear)
            s_d = '0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign target = s_q.tgt;

    a_clear_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && clear) |=> target == '0)
        else $error("Ratio clear did not zero target");

endmodule

// ==== quad_source.sv ====
// Model of the external quadrature or step/direction source
`timescale 1ns/1ps
module quad_source
(
    // Clock
    input  wire logic clk,
    // Follow pins
    output logic      in_a,
    output logic      in_b
);
    logic [1:0] ph_q = 2'b00;
    initial {in_a, in_b} = 2'b00;
    // Gray steps only, three cycles apart so the synchroniser sees each edge
    task automatic quad(input int n, input logic up);
        ph_q = {in_a, in_b};
        repeat (n)
        begin
            @(negedge clk);
            ph_q = up ? {ph_q[0], ~ph_q[1]} : {~ph_q[0], ph_q[1]};
            {in_a, in_b} = ph_q;
            repeat (2) @(negedge clk);
        end
    endtask
    // Faulty source: both phases flip at once
    task automatic jump();
        @(negedge clk);
        {in_a, in_b} = ~{in_a, in_b};
    endtask
    // Step on rising A, direction on B with low meaning up
    task automatic step(input int n, input logic up);
        repeat (n)
        begin
            @(negedge clk);
            in_b = ~up;
            repeat (2) @(negedge clk);
            in_a = 1'b1;
            repeat (2) @(negedge clk);
            in_a = 1'b0;
        end
    endtask
endmodule

// ==== follow_front_end_tb.sv ====
// Self-checking bench for the follow front end
`timescale 1ns/1ps
`include "follow_params.svh"
module follow_front_end_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        cmd_strobe = 1'b0;
    logic [3:0]  cmd_code = 4'h0;
    logic [31:0] cmd_value = 32'h0;
    logic [15:0] flags = 16'h0080;
    logic        in_a, in_b, follow_active, cmd_reject;
    logic [31:0] aux_counter, follow_target, t0;
    logic [7:0]  mode_query, status_byte;
    logic [15:0] status_word;
    int          miscompares = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    quad_source u_quad_source (.clk(clk), .in_a(in_a), .in_b(in_b));
    follow_front_end u_follow_front_end (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .IN_A(in_a), .IN_B(in_b), .CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code),
        .CMD_VALUE(cmd_value), .HOST_MODE_LETTER(`LTR_P), .STATE_FLAGS(flags),
        .AUX_COUNTER(aux_counter), .FOLLOW_TARGET(follow_target),
        .FOLLOW_ACTIVE(follow_active), .MODE_QUERY(mode_query),
        .STATUS_BYTE_QUERY(status_byte), .STATUS_WORD_QUERY(status_word),
        .CMD_REJECT(cmd_reject));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Refusal is a one-cycle pulse, so it is looked at in the cycle after the take
    task automatic cmd(input logic [3:0] c, input logic [31:0] v, input logic rej);
        @(negedge clk);
        {cmd_strobe, cmd_code, cmd_value} = {1'b1, c, v};
        @(negedge clk);
        cmd_strobe = 1'b0;
        chk({31'h0, cmd_reject}, {31'h0, rej}, "refusal");
        repeat (2) @(negedge clk);
    endtask
    task automatic t_track();
        u_quad_source.quad(5, 1'b1);
        cmd(`CMD_ENC_TRACK, 32'h0, 1'b0);
        chk(aux_counter, 32'h0, "track clear");
        u_quad_source.quad(4, 1'b1);
        u_quad_source.quad(6, 1'b0);
        repeat (6) @(negedge clk);
        chk(aux_counter, 32'hffff_fffe, "track count");
        u_quad_source.jump();
        repeat (6) @(negedge clk);
        chk(aux_counter, 32'hffff_fffe, "double change");
        cmd(`CMD_STEP_TRACK, 32'h0, 1'b0);
        chk(aux_counter, 32'h0, "step clear");
        u_quad_source.step(3, 1'b1);
        u_quad_source.step(1, 1'b0);
        repeat (6) @(negedge clk);
        chk(aux_counter, 32'h2, "step count");
        $display("track test done");
    endtask
    task automatic t_modes();
        logic [3:0] codes [6] = '{`CMD_STEP_FOLLOW, `CMD_CAM, `CMD_HALF_RES,
                                  `CMD_QUARTER_RES, `CMD_FULL_RES, `CMD_HOST_MODE};
        logic [7:0] ltrs [6] = '{`LTR_S, `LTR_C, `LTR_F, `LTR_F, `LTR_F, `LTR_P};
        for (int i = 0; i < 6; i++)
        begin
            cmd(codes[i], 32'h0, 1'b0);
            chk({24'h0, mode_query}, {24'h0, ltrs[i]}, "mode letter");
            chk({31'h0, follow_active}, {31'h0, i < 5}, "follow active");
        end
        // Any four steps in a row hold two even and one zero sub-count
        cmd(`CMD_HALF_RES, 32'h0, 1'b0);
        t0 = aux_counter;
        u_quad_source.quad(4, 1'b1);
        repeat (6) @(negedge clk);
        chk(aux_counter, t0 + 32'h2, "half res count");
        cmd(`CMD_QUARTER_RES, 32'h0, 1'b0);
        t0 = aux_counter;
        u_quad_source.quad(4, 1'b0);
        repeat (6) @(negedge clk);
        chk(aux_counter, t0 - 32'h1, "quarter res count");
        cmd(`CMD_FULL_RES, 32'h0, 1'b0);
        cmd(`CMD_ENC_TRACK, 32'h0, 1'b1);
        cmd(`CMD_STEP_TRACK, 32'h0, 1'b1);
        cmd(4'hf, 32'h0, 1'b1);
        chk({24'h0, mode_query}, {24'h0, `LTR_F}, "state kept");
        $display("mode test done");
    endtask
    task automatic t_ratio();
        cmd(`CMD_SET_SHIFT, 32'h0, 1'b0);
        cmd(`CMD_SET_MUL, 32'h100, 1'b0);
        cmd(`CMD_SET_DIV, 32'h1, 1'b0);
        cmd(`CMD_ENC_RATIO, 32'h0, 1'b1);
        cmd(`CMD_SET_MUL, 32'h2, 1'b0);
        cmd(`CMD_ENC_RATIO, 32'h0, 1'b0);
        chk({24'h0, mode_query}, {24'h0, `LTR_X}, "ratio letter");
        t0 = follow_target;
        u_quad_source.quad(4, 1'b1);
        repeat (6) @(negedge clk);
        chk(follow_target, t0 + 32'h8, "ratio target");
        t0 = follow_target;
        cmd(`CMD_SET_SHIFT, 32'h0000_0003, 1'b0);
        repeat (10) @(negedge clk);
        chk(follow_target, t0 + 32'h3, "phase shift");
        cmd(`CMD_STEP_RATIO, 32'h0, 1'b1);
        cmd(`CMD_STEP_FOLLOW, 32'h0, 1'b0);
        cmd(`CMD_STEP_RATIO, 32'h0, 1'b0);
        chk({24'h0, mode_query}, {24'h0, `LTR_X}, "step ratio letter");
        chk({31'h0, follow_active}, 32'h1, "step ratio active");
        $display("ratio test done");
    endtask
    task automatic t_status();
        @(negedge clk);
        flags = 16'ha5c3;
        repeat (2) @(negedge clk);
        chk({24'h0, status_byte}, 32'hc3, "status byte");
        chk({16'h0, status_word}, 32'ha5c3, "status word");
        cmd(`CMD_STOP, 32'h0, 1'b0);
        chk({24'h0, mode_query}, {24'h0, `LTR_O}, "stop letter");
        chk({31'h0, follow_active}, 32'h0, "stop inactive");
        // Enable low: the strobe is not taken and the flags are not sampled
        ce = 1'b0;
        flags = 16'h0000;
        cmd(4'hf, 32'h0, 1'b0);
        chk({24'h0, status_byte}, 32'hc3, "frozen by enable");
        ce = 1'b1;
        repeat (2) @(negedge clk);
        chk({24'h0, mode_query}, {24'h0, `LTR_P}, "off letter");
        $display("status test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        chk({24'h0, mode_query}, {24'h0, `LTR_O}, "reset letter");
        t_track();
        t_modes();
        t_ratio();
        t_status();
        final_report();
    end
    // The whole run needs about 260 cycles
    initial
    begin
        #20000;
        miscompares++;
        final_report();
    end
endmodule
